// *** design/acc_conversion_control.sv ***
// Control logic of a 10-bit successive-approximation converter
// Function
// - High register holds result bits 9..2, low register bits 1..0.
// - Low register bits 7..2 always read as zero.
// - Input above upper reference gives all ones, no overflow flag.
// - Input below lower reference gives zero in both registers.
// - Four-bit channel field picks input; codes 6,7,9,11 map nowhere.
// - Setting converter-on starts continuous back-to-back conversions.
// - Clearing converter-on stops the converter and any conversion.
// - Completion writes result registers and sets end-of-conversion.
// - Reading high result or writing control clears end-of-conversion.
// - End-of-conversion is read-only; other control bits read/write.
// - Channel change aborts, clears the flag, restarts on new channel.
// - Clock-select bit 6 picks cpu clock divided by 4 or by 2.
// - Reset clears control/status and both result registers.
// - Results are not latched; next completion overwrites both halves.
// - Halt disables the converter; wakeup needs a settling delay.
// - Registers at indices 70h, 71h and 72h of the peripheral map.
`timescale 1ns/1ps
`default_nettype none

module acc_conversion_control #(
  parameter int ADR_W        = 12,
  parameter int SAMPLE_TICKS = 4,
  parameter int SETTLE_TICKS = 2,
  parameter int STAB_COUNT   = acc_pkg::STAB_CYCLES
) (
  // Clock and reset
  input  wire  logic                       clk,
  input  wire  logic                       rst,
  // Wishbone classic slave
  input  wire  logic                       wb_cyc_i,
  input  wire  logic                       wb_stb_i,
  input  wire  logic                       wb_we_i,
  input  wire  logic [ADR_W-1:0]           wb_adr_i,
  input  wire  logic [3:0]                 wb_sel_i,
  input  wire  logic [31:0]                wb_dat_i,
  output logic       [31:0]                wb_dat_o,
  output logic                             wb_ack_o,
  // Power management from the core
  input  wire  logic                       halt_mode,
  // Analog front end
  input  wire  logic                       comparator_high,
  output logic       [3:0]                 analog_channel,
  output logic                             channel_connect,
  output logic                             converter_power,
  output logic                             sample_hold,
  output logic       [acc_pkg::RESULT_W-1:0] trial_code
);
  import acc_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [7:0]       idx);
    hit = (adr[ADR_W-1:2] == {{(ADR_W-10){1'b0}}, idx});
  endfunction : hit

  function automatic logic [RESULT_W-1:0] bit_mask(input logic [3:0] i);
    bit_mask = RESULT_W'(1) << i;
  endfunction : bit_mask

  function automatic logic channel_exists(input logic [3:0] ch);
    channel_exists = !(ch == 4'h6 || ch == 4'h7 ||
                       ch == 4'h9 || ch == 4'hB);
  endfunction : channel_exists

  // ************************************************************
  // State
  // ************************************************************
  acc_csr_s              csr;
  logic [RESULT_W-1:0]   result;
  acc_state_e            state;
  logic [1:0]            div_cnt;
  logic                  tick;
  logic [7:0]            step_cnt;
  logic [3:0]            bit_idx;
  logic [15:0]           stab_cnt;
  logic                  need_stab;
  logic                  comp_q1;
  logic                  comp_q2;
  logic                  comp_q3;
  logic                  comp_filt;
  logic                  done;
  logic [RESULT_W-1:0]   kept;

  // Bus decode; effects happen only at the edge where ack is seen
  logic bus_req;
  logic bus_commit;
  logic csr_write;
  logic high_read;
  logic chan_change;
  logic run;

  assign bus_req    = wb_cyc_i && wb_stb_i;
  assign bus_commit = bus_req && wb_ack_o;
  assign csr_write  = bus_commit && wb_we_i && wb_sel_i[0] &&
                      hit(wb_adr_i, IDX_CONTROL_STATUS);
  assign high_read  = bus_commit && !wb_we_i &&
                      hit(wb_adr_i, IDX_RESULT_HIGH);
  assign chan_change = csr_write &&
                       (wb_dat_i[3:0] != csr.channel_select);
  // Halt powers the converter down regardless of the on bit
  assign run = csr.converter_on && !halt_mode;

  // ************************************************************
  // Wishbone slave
  // ************************************************************

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // Read data is captured with ack; unmapped words read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o && !wb_we_i) begin
      if (hit(wb_adr_i, IDX_CONTROL_STATUS)) begin
        wb_dat_o <= {24'h00_0000, csr};
      end else if (hit(wb_adr_i, IDX_RESULT_HIGH)) begin
        wb_dat_o <= {24'h00_0000, result[9:2]};
      end else if (hit(wb_adr_i, IDX_RESULT_LOW)) begin
        wb_dat_o <= {24'h00_0000, 6'h00, result[1:0]};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // Control/status register
  // ************************************************************

  // Software fields; the flag is not writable from the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      csr.clock_fast     <= CSR_RESET[POS_CLOCK_FAST];
      csr.converter_on   <= CSR_RESET[POS_CONV_ON];
      csr.reserved       <= CSR_RESET[POS_RESERVED];
      csr.channel_select <= CSR_RESET[3:0];
    end else if (csr_write) begin
      csr.clock_fast     <= wb_dat_i[POS_CLOCK_FAST];
      csr.converter_on   <= wb_dat_i[POS_CONV_ON];
      csr.reserved       <= wb_dat_i[POS_RESERVED];  // Kept as written
      csr.channel_select <= wb_dat_i[3:0];
    end
  end

  // Completion flag: a completion in the clearing cycle still sets it.
  // A channel change aborts the conversion, so no completion can race it.
  always_ff @(posedge clk) begin
    if (rst) begin
      csr.eoc <= CSR_RESET[POS_EOC];
    end else if (done) begin
      csr.eoc <= 1'b1;
    end else if (csr_write || high_read) begin
      csr.eoc <= 1'b0;
    end
  end

  // Result is overwritten by every completion, no shadow copy
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= RESULT_RESET;
    end else if (done) begin
      result <= kept;
    end
  end

  // ************************************************************
  // Converter clock enable
  // ************************************************************

  // Divider restarts when idle so the first tick has a fixed phase
  always_ff @(posedge clk) begin
    if (rst || state == ST_OFF || tick) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  assign tick = (div_cnt == (csr.clock_fast ? DIV_FAST_LAST
                                            : DIV_SLOW_LAST));

  // ************************************************************
  // Comparator input synchroniser
  // ************************************************************

  // Three stages; the filtered level moves only when the last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      comp_q1   <= 1'b0;
      comp_q2   <= 1'b0;
      comp_q3   <= 1'b0;
      comp_filt <= 1'b0;
    end else begin
      comp_q1 <= comparator_high;
      comp_q2 <= comp_q1;
      comp_q3 <= comp_q2;
      if (comp_q2 == comp_q3) begin
        comp_filt <= comp_q3;
      end
    end
  end

  // ************************************************************
  // Halt wakeup tracking
  // ************************************************************

  // Any halt forces a settling wait before the next conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      need_stab <= 1'b0;
    end else if (halt_mode) begin
      need_stab <= 1'b1;
    end else if (state == ST_STAB && stab_cnt == 16'(STAB_COUNT - 1)) begin
      need_stab <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state != ST_STAB) begin
      stab_cnt <= 16'h0000;
    end else begin
      stab_cnt <= stab_cnt + 16'h0001;
    end
  end

  // ************************************************************
  // Successive-approximation sequencer
  // ************************************************************

  // A kept bit means the input lies above the trial level; beyond the
  // references the comparator pins every bit high or low, so the code
  // saturates at all ones or all zeros with no separate flag
  assign kept = comp_filt ? trial_code
                          : (trial_code & ~bit_mask(bit_idx));
  assign done = run && !chan_change && tick && state == ST_DECIDE &&
                bit_idx == 4'h0;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      state      <= ST_OFF;
      step_cnt   <= 8'h00;
      bit_idx    <= 4'h0;
      trial_code <= RESULT_RESET;
    end else if (chan_change && state != ST_OFF && state != ST_STAB) begin
      state      <= ST_SAMPLE;
      step_cnt   <= 8'h00;
      bit_idx    <= 4'h0;
      trial_code <= RESULT_RESET;
    end else begin
      case (state)
        ST_OFF: begin
          state    <= need_stab ? ST_STAB : ST_SAMPLE;
          step_cnt <= 8'h00;
        end
        ST_STAB: begin
          if (stab_cnt == 16'(STAB_COUNT - 1)) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (step_cnt == 8'(SAMPLE_TICKS - 1)) begin
              state      <= ST_TRIAL;
              step_cnt   <= 8'h00;
              bit_idx    <= 4'(RESULT_W - 1);
              trial_code <= bit_mask(4'(RESULT_W - 1));
            end else begin
              step_cnt <= step_cnt + 8'h01;
            end
          end
        end
        ST_TRIAL: begin
          // Leaves the analog and the synchroniser time to settle
          if (tick) begin
            if (step_cnt == 8'(SETTLE_TICKS - 1)) begin
              state    <= ST_DECIDE;
              step_cnt <= 8'h00;
            end else begin
              step_cnt <= step_cnt + 8'h01;
            end
          end
        end
        ST_DECIDE: begin
          if (tick) begin
            if (bit_idx == 4'h0) begin
              state      <= ST_SAMPLE;
              trial_code <= RESULT_RESET;
            end else begin
              state      <= ST_TRIAL;
              bit_idx    <= bit_idx - 4'h1;
              trial_code <= kept | bit_mask(bit_idx - 4'h1);
            end
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ************************************************************
  // Analog front-end controls
  // ************************************************************

  // Reserved codes leave the multiplexer open; no interrupt exists,
  // software learns of completion only by polling the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_channel  <= 4'h0;
      channel_connect <= 1'b0;
      converter_power <= 1'b0;
      sample_hold     <= 1'b0;
    end else begin
      analog_channel  <= csr.channel_select;
      channel_connect <= run && channel_exists(csr.channel_select);
      converter_power <= run;
      sample_hold     <= state == ST_SAMPLE;
    end
  end

endmodule : acc_conversion_control

`default_nettype wire

// *** design/acc_pkg.sv ***
// Shared constants and types for the converter control block
package acc_pkg;

  // ************************************************************
  // Register indices; the byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'h70;
  localparam logic [7:0] IDX_RESULT_HIGH    = 8'h71;
  localparam logic [7:0] IDX_RESULT_LOW     = 8'h72;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int         POS_EOC        = 7;
  localparam int         POS_CLOCK_FAST = 6;
  localparam int         POS_CONV_ON    = 5;
  localparam int         POS_RESERVED   = 4;
  localparam logic [7:0] CSR_RESET      = 8'h00;
  localparam logic [9:0] RESULT_RESET   = 10'h000;
  localparam int         RESULT_W       = 10;

  // ************************************************************
  // Converter clock divisors and timing
  // ************************************************************
  localparam logic [1:0] DIV_SLOW_LAST = 2'h3;  // f_cpu / 4
  localparam logic [1:0] DIV_FAST_LAST = 2'h1;  // f_cpu / 2
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAB_NS       = 1000;          // Wakeup settling time
  localparam int STAB_CYCLES   =
    (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Control/status layout
  typedef struct packed {
    logic       eoc;
    logic       clock_fast;
    logic       converter_on;
    logic       reserved;
    logic [3:0] channel_select;
  } acc_csr_s;

  // Conversion sequencer, Gray coded from stab through sample, trial and decide; off to sample and decide to sample change two bits
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_STAB   = 3'b001,
    ST_SAMPLE = 3'b011,
    ST_TRIAL  = 3'b010,
    ST_DECIDE = 3'b110
  } acc_state_e;

endpackage : acc_pkg

// *** verif/acc_conversion_control_asserts.sv ***
// Assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_checker #(parameter int ADR_W = 12) (
  // Clock, reset and register bus
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // Converter side
  input wire logic             halt_mode,
  input wire logic [3:0]       analog_channel,
  input wire logic             channel_connect,
  input wire logic             converter_power,
  input wire logic             sample_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Register index of the access being answered
  logic [9:0] idx;
  assign idx = wb_adr_i[11:2];
  sequence rd_ack_s;
    wb_ack_o && !wb_we_i;
  endsequence
  sequence csr_wr_s;
    wb_ack_o && wb_we_i && wb_sel_i[0] && idx == 10'h070;
  endsequence
  // Channel change while running must restart sampling
  sequence ch_wr_s;
    csr_wr_s ##0 (wb_dat_i[5] && !halt_mode
      && wb_dat_i[3:0] != analog_channel);
  endsequence
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_cycle_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  unmapped_zero_a: assert property (rd_ack_s |->
    idx inside {10'h070, 10'h071, 10'h072} || wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  low_pad_zero_a: assert property (rd_ack_s |->
    wb_dat_o[31:8] == 24'h0 && (idx != 10'h072 || wb_dat_o[7:2] == 6'h00))
    else $error("padding bits of read data not zero");
  channel_copy_a: assert property (csr_wr_s |->
    ##2 analog_channel == $past(wb_dat_i[3:0], 2))
    else $error("channel output does not follow write");
  reserved_open_a: assert property (channel_connect |->
    !(analog_channel inside {4'h6, 4'h7, 4'h9, 4'hB}))
    else $error("reserved channel connected");
  restart_a: assert property (ch_wr_s |-> ##[2:8] sample_hold)
    else $error("no sampling after channel change");
  halt_off_a: assert property (halt_mode ##1 halt_mode |=>
    !converter_power)
    else $error("converter powered during halt");
  off_quiet_a: assert property (!converter_power [*3] |->
    !sample_hold)
    else $error("sampling while converter off");
endmodule : acc_checker
bind acc_conversion_control acc_checker #(.ADR_W(ADR_W)) u_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .halt_mode(halt_mode), .analog_channel(analog_channel),
  .channel_connect(channel_connect), .converter_power(converter_power),
  .sample_hold(sample_hold));
`default_nettype wire

// *** verif/acc_conversion_control_test.sv ***
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_conversion_control_test;
  import acc_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam int TICKS = 4 + 10 * (2 + 1);
  logic        clk, rst, cyc, stb, we, halt, cmp, ack, conn, power, hold;
  logic [11:0] adr;
  logic [3:0]  sel, chan;
  logic [31:0] dat_i, dat_o, rdata;
  logic [9:0]  trial;
  int          err_count, num_checks, ain, a;
  typedef struct {logic [31:0] v; logic [31:0] m; string n;} acc_note_s;
  acc_note_s   notes[$];
  acc_note_s   note;
  acc_conversion_control #(.SAMPLE_TICKS(4), .SETTLE_TICKS(2),
    .STAB_COUNT(2)) uut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .halt_mode(halt), .comparator_high(cmp),
    .analog_channel(chan), .channel_connect(conn),
    .converter_power(power), .sample_hold(hold), .trial_code(trial));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Half-code offset so that a settled conversion returns ain exactly
  always @(posedge clk) cmp <= (2 * ain + 1 > 2 * int'(trial));
  // ****************************************
  // Compare, verdict and bus tasks
  // ****************************************
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Read answers are judged against the oldest note; mask 0 skips polls
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = notes.pop_front();
      if (note.m != 32'h0) check(note.n, note.v & note.m, dat_o & note.m);
    end
  end
  // One classic cycle; the request stands until ack is sampled high
  task automatic bus(input logic w, input logic [9:0] i,
                     input logic [7:0] d, input logic [31:0] m,
                     input string n);
    int k;
    if (!w) notes.push_back('{{24'h0, d}, m, n});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat_i <= {24'h0, d};
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
    if (ack !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    rdata = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wait_flag();
    int k;
    for (k = 0; k < 300; k++) begin
      bus(1'b0, 10'h070, 8'h00, 32'h0, "poll");
      if (rdata[7] === 1'b1) break;
    end
    if (k == 300) check("completion flag", 32'h1, 32'h0);
  endtask : wait_flag
  // Two flushes so the judged result comes from the new input level
  task automatic convert(input int v, input logic [9:0] r);
    ain = v;
    repeat (2) begin
      bus(1'b0, 10'h071, 8'h00, 32'h0, "flush");
      wait_flag();
    end
    bus(1'b0, 10'h072, {6'h00, r[1:0]}, '1, "low result");
    bus(1'b0, 10'h071, r[9:2], '1, "high result");
    bus(1'b0, 10'h070, 8'h00, 32'h80, "flag after read");
  endtask : convert
  // Cycles between two starts of sampling; the first start seen may be
  // a restart with an arbitrary divider phase, so it is skipped
  task automatic period(input int e);
    int k, n, t0;
    logic p;
    n = 0;
    p = 1'b1;
    for (k = 0; k < 600 && n < 3; k++) begin
      @(posedge clk);
      if (hold === 1'b1 && p === 1'b0) begin
        n++;
        if (n == 2) t0 = k;
        else if (n == 3)
          check("conversion period", 32'(e), 32'(k - t0));
      end
      p = hold;
    end
    if (n < 3) check("continuous conversion", 32'h1, 32'h0);
  endtask : period
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_count = 0;
    num_checks = 0;
    ain = 0;
    cmp = 1'b0;
    {cyc, stb, we, halt} = 4'h0;
    adr = 12'h000;
    sel = 4'hF;
    dat_i = 32'h0;
    rst = 1'b1;
    void'($urandom(32'h00e3509c));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 10'h071, 8'hFF, 32'h0, "");
    bus(1'b1, 10'h072, 8'hFF, 32'h0, "");
    bus(1'b1, 10'h073, 8'hFF, 32'h0, "");
    // Control write without byte lane 0 must be dropped
    sel <= 4'hE;
    bus(1'b1, 10'h070, 8'h25, 32'h0, "");
    sel <= 4'hF;
    for (int j = 0; j < 4; j++)
      bus(1'b0, 10'(10'h070 + j), 8'h00, '1, "reset or ignored");
    $display("test reset and map done");
    bus(1'b1, 10'h070, 8'hAF, 32'h0, "");
    bus(1'b0, 10'h070, 8'h2F, '1, "control readback");
    period(4 * TICKS);
    bus(1'b1, 10'h070, 8'h63, 32'h0, "");
    period(2 * TICKS);
    $display("test converter clock done");
    for (int c = 0; c < 16; c++) begin
      wait_flag();
      bus(1'b1, 10'h070, 8'h60 | 8'(c), 32'h0, "");
      bus(1'b0, 10'h070, 8'h60 | 8'(c), '1, "flag after switch");
      check("channel", 32'(c), {28'h0, chan});
      check("connect", {31'h0, !(c inside {6, 7, 9, 11})},
            {31'h0, conn});
    end
    $display("test channel select done");
    bus(1'b1, 10'h070, 8'h63, 32'h0, "");
    convert(2000, 10'h3FF);
    convert(-5, 10'h000);
    convert(682, 10'h2AA);
    repeat (3) begin
      a = int'($urandom_range(0, 1023));
      convert(a, 10'(a));
    end
    $display("test conversion results done");
    bus(1'b1, 10'h070, 8'h43, 32'h0, "");
    repeat (300) @(posedge clk);
    bus(1'b0, 10'h070, 8'h43, '1, "no completion when off");
    check("power when off", 32'h0, {31'h0, power});
    bus(1'b1, 10'h070, 8'h63, 32'h0, "");
    repeat (40) @(posedge clk);
    halt <= 1'b1;
    repeat (4) @(posedge clk);
    check("power in halt", 32'h0, {31'h0, power});
    halt <= 1'b0;
    a = int'($urandom_range(0, 1023));
    convert(a, 10'(a));
    $display("test off and halt done");
    give_verdict();
  end
endmodule : acc_conversion_control_test
`default_nettype wire
